/* design/lps_ctrl.sv */
`timescale 1ns/100ps
`include "lps_defs.svh"
// Overview of operation
// - halt request asserted in run or resume moves the core into the clock-halt grant state
// - in halt grant core clocks stop; bus and interrupt-controller clocks keep running
// - in halt grant bus snooping continues and incoming interrupts are latched
// - halt release restarts all clocks, then services latched interrupts as resume ends, also when halt returns in that cycle and execution does not resume
// - halt request is asynchronous and never touches the bus clock
// - sleep request while in halt grant moves into sleep
// - in sleep every unit clock stops; only the PLL runs
// - in sleep no snoop response and no interrupt recognition
// - in sleep only sleep and reset inputs have any effect
// - sleep release returns to halt grant, restarting bus and interrupt clocks
// - management interrupt is accepted asynchronously at any time except in sleep
// - accepted management interrupt saves state and enters management mode
// - in management mode an acknowledge is issued, then the handler runs
// - reset forces a known state from any power state, caches invalidated
module lps_ctrl
    import lps_pkg::*;
(
    input wire logic CORE_CLK_I,                // 100 MHz bus clock
    input wire logic RESET_I,                   // async reset, active high
    input wire logic CLOCK_HALT_REQUEST_N_I,    // async halt request, active low
    input wire logic SLEEP_REQUEST_N_I,         // async sleep request, active low
    input wire logic SYSTEM_MGMT_IRQ_N_I,       // async management interrupt, active low
    input wire logic INTR_I,                    // interrupt event, one-cycle pulse
    input wire logic SNOOP_REQ_I,               // bus snoop request, one-cycle pulse
    input wire logic HANDLER_DONE_I,            // management handler finished, pulse
    output logic CORE_CLK_EN_O,                 // core units clock enable
    output logic BUS_CLK_EN_O,                  // bus and interrupt-controller clock enable
    output logic EXEC_EN_O,                     // instruction execution allowed
    output logic SNOOP_ACK_O,                   // snoop answered, pulse
    output logic INTR_SERVICE_O,                // latched interrupt serviced, pulse
    output logic STATE_SAVE_O,                  // execution state save strobe, pulse
    output logic MGMT_ACK_O,                    // management acknowledge transaction, pulse
    output logic SYSTEM_MANAGEMENT_MODE_O,      // in management mode
    output logic CACHE_INVALIDATE_O             // invalidate caches, no write-back
);
    // =====================================================
    // input synchronisers
    logic halt_n_sync;
    logic sleep_n_sync;
    logic irq_n_sync;
    logic irq_n_prev_reg;
    logic irq_pend_reg;
    logic intr_pend_reg;
    logic [3:0] cnt_reg;
    power_state_e state_reg;
    power_state_e state_next;

    lps_sync u_sync_halt (.clk_i(CORE_CLK_I), .rst_i(RESET_I), .d_i(CLOCK_HALT_REQUEST_N_I), .q_o(halt_n_sync));
    lps_sync u_sync_sleep (.clk_i(CORE_CLK_I), .rst_i(RESET_I), .d_i(SLEEP_REQUEST_N_I), .q_o(sleep_n_sync));
    lps_sync u_sync_irq (.clk_i(CORE_CLK_I), .rst_i(RESET_I), .d_i(SYSTEM_MGMT_IRQ_N_I), .q_o(irq_n_sync));

    wire halt_req = !halt_n_sync;
    wire sleep_req = !sleep_n_sync;
    wire irq_edge = irq_n_prev_reg && !irq_n_sync;
    wire sleeping = (state_reg == ST_SLEEP);

    // =====================================================
    // management interrupt capture; sleep ignores it, set wins over clear
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_n_prev_reg <= 1'b1;
            irq_pend_reg <= 1'b0;
        end else begin
            irq_n_prev_reg <= irq_n_sync;
            if (irq_edge && !sleeping)
                irq_pend_reg <= 1'b1;
            else if (state_reg == ST_MGMT_SAVE)
                irq_pend_reg <= 1'b0;
        end
    end

    // =====================================================
    // interrupt latch; held through halt grant so none is lost
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            intr_pend_reg <= 1'b0;
        end else begin
            if (INTR_I && !sleeping)
                intr_pend_reg <= 1'b1;
            else if (state_reg == ST_RESUME && cnt_reg == 4'h0)
                intr_pend_reg <= 1'b0;
        end
    end

    // =====================================================
    // power state sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (halt_req)
                    state_next = ST_HALT_GRANT;
                else if (irq_pend_reg)
                    state_next = ST_MGMT_SAVE;
            end
            ST_HALT_GRANT: begin
                if (sleep_req)
                    state_next = ST_SLEEP;
                else if (!halt_req)
                    state_next = ST_RESUME;
            end
            ST_SLEEP: begin
                if (!sleep_req)
                    state_next = ST_HALT_GRANT;
            end
            ST_RESUME: begin
                if (halt_req)
                    state_next = ST_HALT_GRANT;
                else if (cnt_reg == 4'h0)
                    state_next = ST_RUN;
            end
            ST_MGMT_SAVE: begin
                if (cnt_reg == 4'h0)
                    state_next = ST_MGMT_ACK;
            end
            ST_MGMT_ACK: state_next = ST_MGMT_RUN;
            ST_MGMT_RUN: begin
                if (HANDLER_DONE_I)
                    state_next = ST_RUN;
            end
            default: state_next = ST_RUN;
        endcase
    end
    // sleep request outside halt grant and sleep is simply not looked at above

    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I)
            state_reg <= ST_RUN;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cnt_reg <= 4'h0;
        end else if (state_next != state_reg) begin
            if (state_next == ST_RESUME)
                cnt_reg <= `RESUME_CYCLES;
            else if (state_next == ST_MGMT_SAVE)
                cnt_reg <= `SAVE_CYCLES;
            else
                cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    // =====================================================
    // registered outputs; clock enables, exec and mode flags derived from the next state so they align with it
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            CORE_CLK_EN_O <= 1'b1;
            BUS_CLK_EN_O <= 1'b1;
            EXEC_EN_O <= 1'b0;
            SYSTEM_MANAGEMENT_MODE_O <= 1'b0;
            CACHE_INVALIDATE_O <= 1'b1;
        end else begin
            CORE_CLK_EN_O <= !(state_next inside {ST_HALT_GRANT, ST_SLEEP});
            BUS_CLK_EN_O <= (state_next != ST_SLEEP);
            EXEC_EN_O <= (state_next inside {ST_RUN, ST_MGMT_RUN});
            SYSTEM_MANAGEMENT_MODE_O <= (state_next inside {ST_MGMT_SAVE, ST_MGMT_ACK, ST_MGMT_RUN});
            CACHE_INVALIDATE_O <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            SNOOP_ACK_O <= 1'b0;
            INTR_SERVICE_O <= 1'b0;
            STATE_SAVE_O <= 1'b0;
            MGMT_ACK_O <= 1'b0;
        end else begin
            SNOOP_ACK_O <= SNOOP_REQ_I && !sleeping;
            INTR_SERVICE_O <= intr_pend_reg && state_reg == ST_RESUME && cnt_reg == 4'h0;
            STATE_SAVE_O <= (state_reg != ST_MGMT_SAVE) && (state_next == ST_MGMT_SAVE);
            MGMT_ACK_O <= (state_next == ST_MGMT_ACK);
        end
    end

    // =====================================================
    // checks
    a_halt_entry: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_RUN && halt_req) |=> state_reg == ST_HALT_GRANT)
        else $error("halt request did not enter halt grant");
    a_halt_clocks: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        state_reg == ST_HALT_GRANT |-> !CORE_CLK_EN_O && BUS_CLK_EN_O)
        else $error("wrong clock enables in halt grant");
    a_sleep_clocks: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        state_reg == ST_SLEEP |-> !CORE_CLK_EN_O && !BUS_CLK_EN_O)
        else $error("clocks running in sleep");
    a_sleep_snoop: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (sleeping && SNOOP_REQ_I) |=> !SNOOP_ACK_O)
        else $error("snoop answered in sleep");
    a_halt_snoop: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_HALT_GRANT && SNOOP_REQ_I) |=> SNOOP_ACK_O)
        else $error("snoop dropped in halt grant");
    a_sleep_entry: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_HALT_GRANT && sleep_req) |=> sleeping)
        else $error("sleep not entered");
    a_sleep_exit: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (sleeping && !sleep_req) |=> state_reg == ST_HALT_GRANT ##1 BUS_CLK_EN_O)
        else $error("sleep exit wrong");
    a_sleep_ignored: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_RUN && !halt_req && !irq_pend_reg) |=> state_reg == ST_RUN)
        else $error("left run without cause");
    a_mgmt_ack: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        $rose(STATE_SAVE_O) |-> ##[4:6] MGMT_ACK_O)
        else $error("management acknowledge missing");
    a_resume_intr: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_HALT_GRANT && !halt_req && !sleep_req && intr_pend_reg) |-> ##[5:6] INTR_SERVICE_O)
        else $error("latched interrupt not serviced");
    a_halt_latch: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_HALT_GRANT && INTR_I) |=> intr_pend_reg)
        else $error("interrupt not latched in halt grant");
    a_sleep_intr: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (sleeping && !intr_pend_reg) |=> !intr_pend_reg)
        else $error("interrupt latched in sleep");
    a_mgmt_entry: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_RUN && !halt_req && irq_pend_reg) |=> STATE_SAVE_O && SYSTEM_MANAGEMENT_MODE_O)
        else $error("management entry without state save");
    a_resume_run: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_RESUME && !halt_req && cnt_reg == 4'h0) |=> EXEC_EN_O && CORE_CLK_EN_O)
        else $error("resume did not restart execution");
    a_resume_halt: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state_reg == ST_RESUME && halt_req) |=> state_reg == ST_HALT_GRANT)
        else $error("halt during resume not granted");
endmodule : lps_ctrl

/* design/lps_defs.svh */
`ifndef LPS_DEFS_SVH
`define LPS_DEFS_SVH
// =====================================================
// synchroniser and sequencing constants
`define SYNC_STAGES 2
`define RESUME_CYCLES 4'h4
`define SAVE_CYCLES 4'h3
`endif

/* design/lps_pkg.sv */
package lps_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_HALT_GRANT,
        ST_SLEEP,
        ST_RESUME,
        ST_MGMT_SAVE,
        ST_MGMT_ACK,
        ST_MGMT_RUN
    } power_state_e;
endpackage : lps_pkg

/* design/lps_sync.sv */
`timescale 1ns/100ps
// =====================================================
// two-stage level synchroniser; resets to the inactive (high) level
module lps_sync (
    input wire logic clk_i, // clock
    input wire logic rst_i, // async reset, active high
    input wire logic d_i,   // asynchronous input
    output logic q_o        // synchronised level
);
    logic meta_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : lps_sync

/* tb/lps_chipset.sv */
`timescale 1ns/100ps
// =====================================================
// chipset side of the power pins
// pins idle high, as the board pull-ups would leave them
module lps_chipset (
    input wire logic halt_i,  // ask for clock halt
    input wire logic sleep_i, // ask for sleep
    input wire logic mgmt_i,  // raise management interrupt
    output logic halt_n_o,    // halt pin
    output logic sleep_n_o,   // sleep pin
    output logic mgmt_n_o     // management interrupt pin
);
    assign halt_n_o = ~halt_i;
    assign sleep_n_o = ~sleep_i;
    assign mgmt_n_o = ~mgmt_i;
endmodule : lps_chipset

/* tb/lps_ctrl_tb.sv */
`timescale 1ns/100ps
module lps_ctrl_tb;
    logic clk = 1'b0, rst = 1'b1, halt = 1'b0, sleep = 1'b0, mgmt = 1'b0;
    logic intr = 1'b0, snoop = 1'b0, done = 1'b0;
    logic halt_n, sleep_n, mgmt_n, core_en, bus_en, exec_en, ack, svc, save, mack, mode, inval;
    integer n_errors = 0, checked = 0, st = 0, seed = 99142;
    integer n_ack = 0, n_svc = 0, n_save = 0, n_mack = 0;
    integer k = 0, base = 0;
    always #5 clk = ~clk;
    lps_chipset u_chip (.halt_i(halt), .sleep_i(sleep), .mgmt_i(mgmt),
        .halt_n_o(halt_n), .sleep_n_o(sleep_n), .mgmt_n_o(mgmt_n));
    lps_ctrl u_dut (.CORE_CLK_I(clk), .RESET_I(rst), .CLOCK_HALT_REQUEST_N_I(halt_n),
        .SLEEP_REQUEST_N_I(sleep_n), .SYSTEM_MGMT_IRQ_N_I(mgmt_n), .INTR_I(intr),
        .SNOOP_REQ_I(snoop), .HANDLER_DONE_I(done), .CORE_CLK_EN_O(core_en),
        .BUS_CLK_EN_O(bus_en), .EXEC_EN_O(exec_en), .SNOOP_ACK_O(ack),
        .INTR_SERVICE_O(svc), .STATE_SAVE_O(save), .MGMT_ACK_O(mack),
        .SYSTEM_MANAGEMENT_MODE_O(mode), .CACHE_INVALIDATE_O(inval));
    // =====================================================
    // pulse counters
    always @(posedge clk) begin
        n_ack <= n_ack + (ack === 1'b1);
        n_svc <= n_svc + (svc === 1'b1);
        n_save <= n_save + (save === 1'b1);
        n_mack <= n_mack + (mack === 1'b1);
    end
    // =====================================================
    // checking
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    // core, bus and exec enables per model state: run, halt grant, sleep
    function automatic logic [7:0] lv(input integer s);
        lv = (s == 0) ? 8'h07 : (s == 1) ? 8'h02 : 8'h00;
    endfunction : lv
    task automatic lvl();
        chk("enables", {5'h0, core_en, bus_en, exec_en}, lv(st));
    endtask : lvl
    task automatic cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic blip(input logic with_intr);
        snoop = 1'b1;
        intr = with_intr;
        cyc(1);
        snoop = 1'b0;
        intr = 1'b0;
    endtask : blip
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        #20000;
        n_errors++;
        conclude();
    end
    // =====================================================
    // scenarios
    initial begin
        cyc(16);
        chk("reset", {6'h0, inval, core_en}, 8'h03);
        rst = 1'b0;
        cyc(2);
        chk("invalidate", {7'h0, inval}, 8'h00);
        lvl();
        sleep = 1'b1;
        cyc(6);
        lvl();
        sleep = 1'b0;
        cyc(4);
        $display("test sleep outside halt done");
        halt = 1'b1;
        cyc(5);
        st = 1;
        lvl();
        blip(1'b0);
        cyc(3);
        chk("snoop acks", n_ack[7:0], 8'h01);
        sleep = 1'b1;
        cyc(5);
        st = 2;
        lvl();
        blip(1'b1);
        mgmt = 1'b1;
        cyc(3);
        mgmt = 1'b0;
        cyc(3);
        chk("snoop acks", n_ack[7:0], 8'h01);
        chk("saves", n_save[7:0], 8'h00);
        sleep = 1'b0;
        cyc(5);
        st = 1;
        lvl();
        blip(1'b1);
        cyc(2);
        chk("snoop acks", n_ack[7:0], 8'h02);
        halt = 1'b0;
        cyc(15);
        st = 0;
        lvl();
        chk("services", n_svc[7:0], 8'h01);
        chk("saves", n_save[7:0], 8'h00);
        $display("test halt and sleep done");
        cyc(1 + ($random(seed) & 7));
        mgmt = 1'b1;
        cyc(8);
        chk("mgmt entry", {6'h0, mode, n_save[0]}, 8'h03);
        cyc(6);
        chk("mgmt ack", {6'h0, exec_en, n_mack[0]}, 8'h03);
        mgmt = 1'b0;
        done = 1'b1;
        cyc(1);
        done = 1'b0;
        cyc(3);
        chk("mode left", {7'h0, mode}, 8'h00);
        $display("test management done");
        halt = 1'b1;
        sleep = 1'b1;
        cyc(10);
        rst = 1'b1;
        cyc(2);
        chk("reset in sleep", {6'h0, inval, bus_en}, 8'h03);
        halt = 1'b0;
        sleep = 1'b0;
        rst = 1'b0;
        cyc(3);
        lvl();
        $display("test reset in sleep done");
        halt = 1'b1;
        cyc(5);
        st = 1;
        lvl();
        k = 1 + ($random(seed) & 3);
        base = n_ack;
        repeat (k) begin
            blip(1'b0);
            cyc(1);
        end
        cyc(2);
        chk("snoop burst", n_ack[7:0] - base[7:0], k[7:0]);
        // release, then ask again while the resume count is still running
        halt = 1'b0;
        cyc(3);
        halt = 1'b1;
        cyc(5);
        lvl();
        halt = 1'b0;
        cyc(10);
        st = 0;
        lvl();
        chk("services", n_svc[7:0], 8'h01);
        $display("test halt during resume done");
        conclude();
    end
endmodule : lps_ctrl_tb
